// >>> hw/iogbt_pkg.sv
/*
 * Constants shared by the I/O group base timer: register indices, field
 * positions, reset values and encodings.
 * Assumes a 32-bit classic Wishbone bus with one register per aligned word.
 */
package iogbt_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned NGRP   = 3;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned IDX_W  = 12;

  // ****************************************************************
  // register indices (byte address = 4 * index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_SRC [NGRP] =
    '{12'h1A2, 12'h122, 12'h162};
  localparam logic [IDX_W-1:0] IDX_RST [NGRP] =
    '{12'h1A3, 12'h123, 12'h163};
  localparam logic [IDX_W-1:0] IDX_FSEL [NGRP] =
    '{12'h1A7, 12'h127, 12'h167};
  localparam logic [IDX_W-1:0] IDX_CNT [NGRP] =
    '{12'h204, 12'h205, 12'h206};
  localparam logic [IDX_W-1:0] IDX_CMP0 [NGRP] =
    '{12'h208, 12'h209, 12'h20A};
  localparam logic [IDX_W-1:0] IDX_START    = 12'h200;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h201;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h202;
  localparam logic [IDX_W-1:0] IDX_BIT9_CFG = 12'h20C;

  // ****************************************************************
  // source control fields
  // ****************************************************************
  localparam int unsigned SRC_LSB    = 0;
  localparam int unsigned DIV_LSB    = 2;
  localparam int unsigned IRQSEL_BIT = 7;
  localparam logic [1:0]  SRC_STOP   = 2'h0;
  localparam logic [1:0]  SRC_QUAD   = 2'h2;
  localparam logic [1:0]  SRC_F1     = 2'h3;
  localparam logic [4:0]  DIV_BYPASS = 5'h1F;

  // ****************************************************************
  // reset control fields (b3 and b7 reserved, read as zero)
  // ****************************************************************
  localparam int unsigned SYNC_BIT   = 0;
  localparam int unsigned MATCH_BIT  = 1;
  localparam int unsigned PIN_BIT    = 2;
  localparam int unsigned RUN_BIT    = 4;
  localparam int unsigned MODE_LSB   = 5;
  localparam logic [7:0]  RST_WMASK  = 8'h77;
  localparam logic [1:0]  MODE_INC   = 2'h0;
  localparam logic [1:0]  MODE_UPDN  = 2'h1;
  localparam logic [1:0]  MODE_QUAD  = 2'h2;

  // ****************************************************************
  // counts and reset values
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CNT_W-1:0] BIT9_MAX = 16'h03FF;
  localparam logic [7:0]       REG8_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;

  typedef enum logic {IOGBT_UP, IOGBT_DOWN} iogbt_dir_t;

endpackage

// >>> hw/iogbt_grp_if.sv
/*
 * Carrier between the register block and one group timer.
 * Assumes iogbt_pkg is compiled first.
 */
interface iogbt_grp_if;
  import iogbt_pkg::*;
  logic [1:0]       src;
  logic [4:0]       div;
  logic             irq_sel;
  logic [1:0]       mode;
  logic             match_en;
  logic             bit9_sel;
  logic [CNT_W-1:0] cmp0;
  logic             ext_rst;
  logic             qedge;
  logic             qdir;
  logic [CNT_W-1:0] count;
  logic             ovf;
  logic             match_rst;

  modport ctl (output src, div, irq_sel, mode, match_en, bit9_sel, cmp0,
               ext_rst, qedge, qdir,
               input  count, ovf, match_rst);
  modport tmr (input  src, div, irq_sel, mode, match_en, bit9_sel, cmp0,
               ext_rst, qedge, qdir,
               output count, ovf, match_rst);
endinterface

// >>> hw/iogbt_sync.sv
/*
 * Two flip-flop synchroniser for pin inputs.
 * Assumes the inputs are asynchronous levels.
 */
module iogbt_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// >>> hw/iogbt_timer.sv
/*
 * One group's 16-bit base timer: prescaler, count modes, match reset and
 * overflow event.
 * Assumes configuration and external reset come from the register block.
 */
module iogbt_timer (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // configuration and status
  iogbt_grp_if.tmr  g
);
  import iogbt_pkg::*;

  logic [5:0]       pre;
  logic             pend;
  iogbt_dir_t       dir;
  iogbt_dir_t       next_dir;
  logic             src_tick;
  logic             tick;
  logic             up;
  logic             next_ovf;
  logic [CNT_W-1:0] top;
  logic [CNT_W-1:0] next_count;
  logic [5:0]       pre_end;

  // ****************************************************************
  // count source and prescaler
  // ****************************************************************
  assign pre_end  = {g.div, 1'b1};
  assign src_tick = (g.src == SRC_F1) ||
                    (g.src == SRC_QUAD && g.qedge);
  assign tick = (g.div == DIV_BYPASS) ? src_tick
              : (src_tick && pre >= pre_end);

  always_ff @(posedge clk_i) begin
    if (rst_i || g.ext_rst) begin
      pre <= '0;
    end else if (src_tick) begin
      pre <= (pre >= pre_end) ? 6'h00 : pre + 6'h01;
    end
  end

  // ****************************************************************
  // next count per mode
  // ****************************************************************
  assign top = g.bit9_sel ? BIT9_MAX : CNT_MAX;

  always_comb begin
    next_dir = dir;
    case (g.mode)
      MODE_INC:  up = 1'b1;
      MODE_QUAD: up = g.qdir;
      MODE_UPDN: up = (dir == IOGBT_UP);
      default:   up = 1'b1;
    endcase
    if (up) begin
      next_count = (g.count >= top) ? CNT_RST : g.count + 16'h0001;
      next_ovf   = g.irq_sel ? (g.count[14] && !next_count[14])
                             : (g.count >= top);
    end else begin
      next_count = g.count - 16'h0001;
      next_ovf   = 1'b0;
    end
    if (g.mode == MODE_UPDN) begin
      if (up && g.count >= top) begin
        next_count = g.count - 16'h0001;
        next_dir   = IOGBT_DOWN;
      end else if (!up && g.count == CNT_RST) begin
        next_count = 16'h0001;
        next_dir   = IOGBT_UP;
      end
    end
  end

  // the reset falls on the first tick after the match tick
  assign g.match_rst = tick && pend;

  always_ff @(posedge clk_i) begin
    if (rst_i || g.ext_rst) begin
      g.count <= CNT_RST;
      pend    <= 1'b0;
      dir     <= IOGBT_UP;
      g.ovf   <= 1'b0;
    end else begin
      g.ovf <= 1'b0;
      if (tick) begin
        if (pend) begin
          g.count <= CNT_RST;
          pend    <= 1'b0;
        end else begin
          g.count <= next_count;
          dir     <= next_dir;
          g.ovf   <= next_ovf;
          pend    <= g.match_en && (g.count == g.cmp0);
        end
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  stopped_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (g.src == SRC_STOP && !g.ext_rst) |=> $stable(g.count))
    else $error("timer moved with the source stopped");

  undivided_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (g.src == SRC_F1 && g.div == DIV_BYPASS && g.mode == MODE_INC &&
     !g.ext_rst && !pend && !g.match_en && !g.bit9_sel)
    |=> g.count == $past(g.count) + 16'h0001)
    else $error("undivided increment did not step by one");

  div_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && g.div != DIV_BYPASS && g.src == SRC_F1 && !g.ext_rst &&
     $stable(g.div)) |=> !tick)
    else $error("divided tick on two cycles in a row");

  match_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && pend) |=> g.count == CNT_RST)
    else $error("match reset did not clear the timer");

  wrap_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && !pend && !g.ext_rst && g.mode == MODE_INC && !g.irq_sel &&
     !g.bit9_sel && g.count == CNT_MAX)
    |=> (g.ovf && g.count == CNT_RST))
    else $error("bit 15 overflow missed or no wrap");
endmodule

// >>> hw/iogbt_top.sv
/*
 * Base timers of three I/O channel groups with their control registers,
 * reset sources, encoder decoding and overflow interrupt.
 * Assumes a classic Wishbone master on clk_i and asynchronous encoder and
 * reset pins, which are synchronised here.
 */
// Register access over Wishbone is this design's own decision.
module iogbt_top
  import iogbt_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone slave
  input  wire logic [13:0]               wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic                      wb_we_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // pins of groups 0 and 1
  input  wire logic [1:0]                enc_a_i,
  input  wire logic [1:0]                enc_b_i,
  input  wire logic [1:0]                ext_irq_pin_n_i,
  // status and channel function select outputs
  output logic                           irq_o,
  output logic      [NGRP*8-1:0]         chan_func_sel_o,
  output logic      [NGRP*CNT_W-1:0]     timer_count_o
);
  import iogbt_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]       src_ctrl [NGRP];
  logic [7:0]       rst_ctrl [NGRP];
  logic [CNT_W-1:0] cmp0     [NGRP];
  logic [NGRP-1:0]  start_reg;
  logic [NGRP-1:0]  irq_stat;
  logic [NGRP-1:0]  irq_mask;
  logic [NGRP-1:0]  bit9_cfg;
  logic [NGRP-1:0]  run_eff;
  logic [NGRP-1:0]  pin_rst;
  logic [NGRP-1:0]  own_rst;
  logic [NGRP-1:0]  ext_rst;
  logic [NGRP-1:0]  ovf_evt;
  logic [NGRP-1:0]  match_rst;
  logic [NGRP-1:0]  next_irq_stat;
  logic [5:0]       pin_sync;
  logic [3:0]       enc_prev;
  logic [1:0]       qedge;
  logic [1:0]       qdir;
  logic [IDX_W-1:0] idx;
  logic             acc;
  logic             wr;
  logic             rd;
  logic [31:0]      next_rdata;

  iogbt_grp_if grp [NGRP] ();

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  iogbt_sync #(
    .W (6)
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({~ext_irq_pin_n_i, enc_b_i, enc_a_i}),
    .q_o   (pin_sync)
  );

  // one encoder step: {edge, up}; a double change is a glitch, not a step
  function automatic logic [1:0] quad_step(input logic [1:0] prev,
                                           input logic [1:0] cur);
    logic chg;
    chg = (prev != cur) && (prev[0] ^ cur[0]) != (prev[1] ^ cur[1]);
    // a leading b counts up: old b against new a gives the direction
    return {chg, prev[1] ^ cur[0]};
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enc_prev <= 4'h0;
    end else begin
      enc_prev <= {pin_sync[3], pin_sync[1], pin_sync[2], pin_sync[0]};
    end
  end

  assign {qedge[0], qdir[0]} = quad_step(enc_prev[1:0],
                                         {pin_sync[2], pin_sync[0]});
  assign {qedge[1], qdir[1]} = quad_step(enc_prev[3:2],
                                         {pin_sync[3], pin_sync[1]});

  // ****************************************************************
  // wishbone decode
  // ****************************************************************
  // one wait state: the access is taken while ack is low, ack follows
  assign idx = wb_adr_i[13:2];
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i && wb_sel_i[0];
  assign rd  = acc && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // ****************************************************************
  // per-group registers and timer
  // ****************************************************************
  for (genvar gi = 0; gi < NGRP; gi++) begin : g_grp
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        src_ctrl[gi] <= REG8_RST;
        rst_ctrl[gi] <= REG8_RST;
        cmp0[gi]     <= CNT_RST;
        chan_func_sel_o[gi*8 +: 8] <= REG8_RST;
      end else if (wr) begin
        if (idx == IDX_SRC[gi]) begin
          src_ctrl[gi] <= wb_dat_i[7:0];
        end
        if (idx == IDX_RST[gi]) begin
          rst_ctrl[gi] <= wb_dat_i[7:0] & RST_WMASK;
        end
        if (idx == IDX_FSEL[gi]) begin
          chan_func_sel_o[gi*8 +: 8] <= wb_dat_i[7:0];
        end
        if (idx == IDX_CMP0[gi] && wb_sel_i[1]) begin
          cmp0[gi] <= wb_dat_i[15:0];
        end
      end
    end

    // run bit or shared start bit lets the group count
    assign run_eff[gi] = rst_ctrl[gi][RUN_BIT] || start_reg[gi];
    assign own_rst[gi] = !run_eff[gi] || pin_rst[gi] ||
                         match_rst[gi];

    assign grp[gi].src      = src_ctrl[gi][SRC_LSB +: 2];
    assign grp[gi].div      = src_ctrl[gi][DIV_LSB +: 5];
    assign grp[gi].irq_sel  = src_ctrl[gi][IRQSEL_BIT];
    assign grp[gi].mode     = rst_ctrl[gi][MODE_LSB +: 2];
    assign grp[gi].match_en = rst_ctrl[gi][MATCH_BIT];
    assign grp[gi].bit9_sel = bit9_cfg[gi];
    assign grp[gi].cmp0     = cmp0[gi];
    assign grp[gi].ext_rst  = ext_rst[gi];
    assign grp[gi].qedge    = (gi < 2) ? qedge[gi % 2] : 1'b0;
    assign grp[gi].qdir     = (gi < 2) ? qdir[gi % 2] : 1'b0;
    assign ovf_evt[gi]      = grp[gi].ovf;
    assign match_rst[gi]    = grp[gi].match_rst;
    assign timer_count_o[gi*CNT_W +: CNT_W] = grp[gi].count;

    iogbt_timer u_timer (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .g     (grp[gi])
    );
  end

  // ****************************************************************
  // reset sources
  // ****************************************************************
  // group 2 has no pin reset here: its third source is the serial block
  assign pin_rst[0] = rst_ctrl[0][PIN_BIT] && pin_sync[4];
  assign pin_rst[1] = rst_ctrl[1][PIN_BIT] && pin_sync[5];
  assign pin_rst[2] = 1'b0;

  // partner terms use only the partner's own sources, so no loop forms
  assign ext_rst[0] = !run_eff[0] || pin_rst[0] ||
                      (rst_ctrl[0][SYNC_BIT] && own_rst[1]);
  assign ext_rst[1] = !run_eff[1] || pin_rst[1] ||
                      (rst_ctrl[1][SYNC_BIT] && own_rst[0]);
  assign ext_rst[2] = !run_eff[2] ||
                      (rst_ctrl[2][SYNC_BIT] && own_rst[1]);

  // ****************************************************************
  // shared registers and interrupt
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_reg <= '0;
      irq_mask  <= '0;
      bit9_cfg  <= '0;
    end else if (wr) begin
      if (idx == IDX_START) begin
        start_reg <= wb_dat_i[NGRP-1:0];
      end
      if (idx == IDX_IRQ_MASK) begin
        irq_mask <= wb_dat_i[NGRP-1:0];
      end
      if (idx == IDX_BIT9_CFG) begin
        bit9_cfg <= wb_dat_i[NGRP-1:0];
      end
    end
  end

  // a new overflow in the clearing read survives it
  assign next_irq_stat = (irq_stat & ~((rd && idx == IDX_IRQ_STAT) ?
                          {NGRP{1'b1}} : {NGRP{1'b0}})) | ovf_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_o    <= |(next_irq_stat & irq_mask);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NGRP; i++) begin
      if (idx == IDX_SRC[i]) begin
        next_rdata[7:0] = src_ctrl[i];
      end
      if (idx == IDX_RST[i]) begin
        next_rdata[7:0] = rst_ctrl[i];
      end
      if (idx == IDX_FSEL[i]) begin
        next_rdata[7:0] = chan_func_sel_o[i*8 +: 8];
      end
      if (idx == IDX_CNT[i]) begin
        next_rdata[15:0] = timer_count_o[i*CNT_W +: CNT_W];
      end
      if (idx == IDX_CMP0[i]) begin
        next_rdata[15:0] = cmp0[i];
      end
    end
    if (idx == IDX_START) begin
      next_rdata[NGRP-1:0] = start_reg;
    end
    if (idx == IDX_IRQ_STAT) begin
      next_rdata[NGRP-1:0] = irq_stat;
    end
    if (idx == IDX_IRQ_MASK) begin
      next_rdata[NGRP-1:0] = irq_mask;
    end
    if (idx == IDX_BIT9_CFG) begin
      next_rdata[NGRP-1:0] = bit9_cfg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  run_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_eff[0] |=> timer_count_o[15:0] == CNT_RST)
    else $error("stopped group 0 timer not held at zero");

  pin_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_rst[1] |=> timer_count_o[31:16] == CNT_RST)
    else $error("pin reset did not clear group 1 timer");

  sync_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rst_ctrl[0][SYNC_BIT] && own_rst[1])
    |=> (timer_count_o[15:0] == CNT_RST && timer_count_o[31:16] == CNT_RST))
    else $error("group 0 did not reset with group 1");

  func_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_FSEL[1])
    |=> chan_func_sel_o[15:8] == $past(wb_dat_i[7:0]))
    else $error("channel function select not stored");

  start_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_START && wb_dat_i[2]) |=> run_eff[2])
    else $error("shared start bit did not start group 2");

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ovf_evt[0] && irq_mask[0] && !wr) |=> (irq_stat[0] && irq_o))
    else $error("overflow did not raise the interrupt");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc |=> wb_ack_o ##1 !wb_ack_o)
    else $error("access not answered in one cycle");
endmodule

// >>> dv/iogbt_pins_model.sv
/*
 * Encoder phases and active-low reset pins for groups 0 and 1.
 * Assumes the bench calls step and pin from one thread at a time.
 */
module iogbt_pins_model (
  // clock
  input  wire logic       clk_i,
  // pins
  output logic      [1:0] enc_a_o,
  output logic      [1:0] enc_b_o,
  output logic      [1:0] pin_n_o
);
  // reset pins idle high as if pulled up; encoder phases start low
  initial begin
    enc_a_o = 2'h0;
    enc_b_o = 2'h0;
    pin_n_o = 2'h3;
  end
  // one x4 step, a leads b going up; each step held 4 clocks
  task automatic step(input int g, input bit up);
    @(posedge clk_i);
    if ((enc_a_o[g] == enc_b_o[g]) == up) begin
      enc_a_o[g] <= ~enc_a_o[g];
    end else begin
      enc_b_o[g] <= ~enc_b_o[g];
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pin(input int g, input bit v);
    @(posedge clk_i);
    pin_n_o[g] <= v;
  endtask
endmodule

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the three group base timers.
 * Assumes iogbt_pkg, the interface and the design are compiled first.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iogbt_pkg::*;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  we    = 1'b0;
  logic                  cyc   = 1'b0;
  logic [13:0]           adr   = 14'h0000;
  logic [31:0]           dat   = 32'h0;
  logic [3:0]            sel   = 4'h0;
  logic [31:0]           rdat;
  logic [31:0]           q;
  logic                  ack;
  logic                  irq;
  logic [1:0]            ea;
  logic [1:0]            eb;
  logic [1:0]            pn;
  logic [NGRP*8-1:0]     fs;
  logic [NGRP*CNT_W-1:0] cnt;
  int                    fail_count = 0;
  int                    n_tests = 0;
  int                    cyc_n = 0;
  always #5 clk_i = ~clk_i;
  iogbt_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .enc_a_i(ea),
    .enc_b_i(eb), .ext_irq_pin_n_i(pn), .irq_o(irq),
    .chan_func_sel_o(fs), .timer_count_o(cnt));
  iogbt_pins_model i_pins (.clk_i(clk_i), .enc_a_o(ea), .enc_b_o(eb),
    .pin_n_o(pn));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle; ack and read data sampled at the same edge
  task automatic acc(input bit w, input logic [11:0] i,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= d;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1 && n++ < 50);
    q = rdat;
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    acc(1'b1, i, d);
  endtask
  task automatic rd(input logic [11:0] i, input logic [31:0] e);
    acc(1'b0, i, 32'h0);
    chk(q, e);
  endtask
  // ticks seen over n clocks, independent of prescaler phase
  task automatic dlt(input int g, input int n, input logic [15:0] e);
    logic [15:0] c0;
    @(posedge clk_i);
    c0 = cnt[16*g +: 16];
    repeat (n) @(posedge clk_i);
    chk(16'(cnt[16*g +: 16] - c0), e);
  endtask
  task automatic wirq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n++ < lim) @(posedge clk_i);
    chk(irq, 1'b1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      fail_count++;
      summarize();
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [15:0] m;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_SRC[0], 32'h0);
    rd(IDX_RST[2], 32'h0);
    rd(12'hFFF, 32'h0);
    wr(IDX_RST[0], 32'hFF);
    rd(IDX_RST[0], 32'h77);
    wr(IDX_RST[0], 32'h0);
    wr(IDX_FSEL[0], 32'hA5);
    chk(fs[7:0], 8'hA5);
    wr(IDX_SRC[0], 32'h7F);
    wr(IDX_RST[0], 32'h10);
    dlt(0, 10, 16'h000A);
    wr(IDX_SRC[0], 32'h07);
    dlt(0, 40, 16'h000A);
    wr(IDX_SRC[0], 32'h7B);
    dlt(0, 620, 16'h000A);
    wr(IDX_SRC[0], 32'h7C);
    dlt(0, 10, 16'h0000);
    wr(IDX_RST[0], 32'h0);
    repeat (3) @(posedge clk_i);
    chk(cnt[15:0], 16'h0000);
    // no other compare channel is modelled, so compare 0 stays the highest
    wr(IDX_CMP0[0], 32'h5);
    wr(IDX_SRC[0], 32'h7F);
    wr(IDX_RST[0], 32'h12);
    m = 16'h0000;
    repeat (40) begin
      @(posedge clk_i);
      if (cnt[15:0] > m) m = cnt[15:0];
    end
    chk(m, 16'h0006);
    wr(IDX_RST[0], 32'h14);
    i_pins.pin(0, 1'b0);
    repeat (6) @(posedge clk_i);
    dlt(0, 10, 16'h0000);
    chk(cnt[15:0], 16'h0000);
    i_pins.pin(0, 1'b1);
    repeat (5) @(posedge clk_i);
    dlt(0, 10, 16'h000A);
    wr(IDX_RST[0], 32'h0);
    wr(IDX_SRC[1], 32'h7F);
    wr(IDX_RST[1], 32'h11);
    dlt(1, 10, 16'h0000);
    wr(IDX_RST[0], 32'h10);
    dlt(1, 10, 16'h000A);
    wr(IDX_SRC[2], 32'h7F);
    wr(IDX_START, 32'h4);
    dlt(2, 10, 16'h000A);
    wr(IDX_RST[0], 32'h0);
    wr(IDX_SRC[0], 32'h7E);
    wr(IDX_RST[0], 32'h50);
    repeat (4) i_pins.step(0, 1'b1);
    repeat (5) @(posedge clk_i);
    chk(cnt[15:0], 16'h0004);
    repeat (2) i_pins.step(0, 1'b0);
    repeat (5) @(posedge clk_i);
    chk(cnt[15:0], 16'h0002);
    wr(IDX_RST[0], 32'h0);
    wr(IDX_SRC[0], 32'h7F);
    wr(IDX_BIT9_CFG, 32'h1);
    rd(IDX_IRQ_STAT, 32'h0);
    wr(IDX_RST[0], 32'h10);
    repeat (1100) @(posedge clk_i);
    chk(irq, 1'b0);
    rd(IDX_IRQ_STAT, 32'h1);
    rd(IDX_IRQ_STAT, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1);
    wirq(1100);
    rd(IDX_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wr(IDX_RST[0], 32'h0);
    wr(IDX_BIT9_CFG, 32'h0);
    wr(IDX_SRC[0], 32'hFF);
    rd(IDX_IRQ_STAT, 32'h0);
    wr(IDX_RST[0], 32'h10);
    repeat (32700) @(posedge clk_i);
    chk(irq, 1'b0);
    wirq(200);
    summarize();
  end
endmodule
